// ### dv/ssdi_controller_model.sv
/* dual-channel safety controller watching the safety outputs.
   assumes channels synchronous to clk */
`timescale 1ns/10ps
module ssdi_controller_model #(
  parameter integer TOL = 5
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // channel pair from the sensor
  input  wire logic ch_a,
  input  wire logic ch_b,
  // verdicts
  output logic      run,
  output logic      mismatch
);
  logic [15:0] off_cnt; // cycles without both channels high
  // short blanking is tolerated, a long gap stops the machine
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      off_cnt  <= 16'h0000;
      run      <= 1'b0;
      mismatch <= 1'b0;
    end
    else
    begin
      mismatch <= mismatch | (ch_a ^ ch_b);
      if (ch_a & ch_b)
      begin
        off_cnt <= 16'h0000;
        run     <= 1'b1;
      end
      else
      begin
        off_cnt <= off_cnt + 16'h0001;
        if (off_cnt >= TOL)
          run <= 1'b0;
      end
    end
endmodule // ssdi_controller_model

// ### dv/ssdi_indicator_bench.sv
/* testbench of the indicator with a controller on the safety outputs.
   assumes shortened timing parameters */
`timescale 1ns/10ps
module ssdi_indicator_bench;
  localparam integer AN = 20;  // analysis cycles
  localparam integer FL = 300; // failure cycles
  localparam integer DH = 5;   // diagnostic half period
  localparam integer BL = 4;   // blanking limit
  reg clk, rst, act, lim, in_a, in_b, req;
  reg  [4:0] flt;              // fault causes, one hot
  wire       g, y, r, d, sa, sb, run, mis;
  wire [5:0] o = {g, y, r, d, sa, sb};
  int        failures, n_compared;
  ssdi_indicator #(.ANALYSIS_CYC(AN), .FAIL_CYC(FL), .DIAG_HALF(DH), .BLANK_CYC(BL),
    .YEL_HALF(4), .PULSE_CYC(3), .GAP_CYC(3), .PAUSE_CYC(10)) DUT (.clk(clk), .rst(rst),
    .actuated(act), .limit_range(lim), .fault_out_a(flt[0]), .fault_out_b(flt[1]),
    .fault_cross(flt[2]), .fault_temp(flt[3]), .fault_coding(flt[4]),
    .safety_input_a(in_a), .safety_input_b(in_b), .selftest_req(req), .led_green(g),
    .led_yellow(y), .led_red(r), .diag_out(d), .safety_output_a(sa), .safety_output_b(sb));
  ssdi_controller_model #(.TOL(BL + 1)) ctl (.clk(clk), .rst(rst), .ch_a(sa), .ch_b(sb),
    .run(run), .mismatch(mis));
  always #10 clk = ~clk;
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task results;
    if (failures == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // actuated in range and in the limit range
  task automatic t_run;
    int dh, yh;
    act = 1; cyc(3);
    chk(o, 8'h17);
    lim = 1; cyc(2); dh = 0; yh = 0;
    repeat (4 * DH)
    begin
      cyc(1); dh += d; yh += y;
    end
    chk(dh, 2 * DH);
    chk(yh > 0 && yh < 4 * DH, 1);
    chk({sa, sb, run}, 8'h07);
    lim = 0; cyc(2);
  endtask
  // chain input lost, then self-test blanking
  task automatic t_chain;
    int   lo;
    logic up;
    in_b = 0; cyc(3);
    chk({sa, sb}, 8'h00);
    in_b = 1; cyc(3);
    req = 1; lo = 0; up = 1;
    repeat (12)
    begin
      cyc(1); lo += !sa; up &= run;
    end
    chk(lo > 0 && lo <= BL, 1);
    chk({up, mis}, 8'h02);
    req = 0; cyc(3);
  endtask
  // one fault class from start to failure state
  task automatic t_fault(input int i);
    int n, dk;
    logic p;
    flt = 5'h01 << i; cyc(4);
    chk({g, y, r}, 8'h01);
    cyc(AN);
    chk({d, sa, sb}, 8'h03);
    dk = 0; n = 0; p = 0;
    while (dk < 8)
    begin
      cyc(1); dk = r ? 0 : dk + 1;
    end
    dk = 0;
    while (dk < 8)
    begin
      cyc(1); n += r & !p; p = r; dk = r ? 0 : dk + 1;
    end
    chk(n, i + 1);
    cyc(FL);
    chk({r, sa, sb, run}, 8'h08);
    flt = 0; cyc(3);
    chk(o, 8'h17);
  endtask
  initial
  begin
    clk = 0; rst = 1; act = 0; lim = 0; req = 0; flt = 0;
    in_a = 1; in_b = 1;
    failures = 0; n_compared = 0;
    cyc(20); rst = 0; cyc(3);
    chk(o, 8'h20);
    t_run;
    t_chain;
    for (int i = 0; i < 5; i++)
      t_fault(i);
    act = 0; cyc(3);
    chk(o, 8'h20);
    results;
  end
  initial
  begin
    #(20 * 30000);
    failures++;
    results;
  end
endmodule // ssdi_indicator_bench

// ### dv/ssdi_indicator_properties.sv
/* output checks of the indicator.
   assumes shortened timing parameters handed on by the bind */
`timescale 1ns/10ps
module ssdi_indicator_properties #(
  parameter integer ANALYSIS_CYC = 20,
  parameter integer FAIL_CYC     = 300,
  parameter integer DIAG_HALF    = 5,
  parameter integer BLANK_CYC    = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // inputs
  input wire logic actuated,
  input wire logic limit_range,
  input wire logic fault_out_a,
  input wire logic fault_out_b,
  input wire logic fault_cross,
  input wire logic fault_temp,
  input wire logic fault_coding,
  input wire logic safety_input_a,
  input wire logic safety_input_b,
  input wire logic selftest_req,
  // outputs
  input wire logic led_green,
  input wire logic led_yellow,
  input wire logic led_red,
  input wire logic diag_out,
  input wire logic safety_output_a,
  input wire logic safety_output_b
);
  localparam int DH = DIAG_HALF + 1; // longest diagnostic half period
  wire flt = fault_out_a | fault_out_b | fault_cross | fault_temp | fault_coding;
  wire chn = safety_input_a & safety_input_b;   // chain inputs both on
  wire ok  = actuated & chn & ~selftest_req;    // enable cause, faults not considered
  wire en  = ok & ~flt;                         // clean enable cause
  reg [15:0] flt_cnt;                           // run of fault cycles
  reg [15:0] req_cnt;                           // run of blanking requests
  reg [15:0] lim_cnt;                           // run of clean limit cycles
  // run length counters
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      flt_cnt <= 16'h0000;
      req_cnt <= 16'h0000;
      lim_cnt <= 16'h0000;
    end
    else
    begin
      flt_cnt <= flt ? flt_cnt + 16'h0001 : 16'h0000;
      req_cnt <= selftest_req ? req_cnt + 16'h0001 : 16'h0000;
      lim_cnt <= (en & limit_range) ? lim_cnt + 16'h0001 : 16'h0000;
    end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_IDLE: assert property (!actuated && !flt |=> led_green && !led_yellow && !diag_out
    && !safety_output_a && !safety_output_b) else $error("idle outputs wrong");
  // leaving the fault states takes one cycle after the fault clears
  AST_RUN: assert property (en && !limit_range && !$past(flt) |=> led_yellow
    && !led_green && diag_out && safety_output_a && safety_output_b)
    else $error("actuated outputs wrong");
  AST_LIMIT: assert property (en && limit_range && !$past(flt) |=> safety_output_a
    && safety_output_b) else $error("limit range dropped outputs");
  AST_PULSE: assert property (lim_cnt > 2 * DIAG_HALF + 4 && diag_out |-> ##[1:DH]
    (!diag_out || lim_cnt == 16'h0000)) else $error("diagnostic not pulsing");
  AST_RED: assert property (flt_cnt > 2 && flt_cnt < ANALYSIS_CYC - 1 |-> led_red
    && !led_green && !led_yellow) else $error("no steady red in analysis");
  AST_DIAG: assert property (flt_cnt > ANALYSIS_CYC + 2 |-> !diag_out)
    else $error("diagnostic high after analysis");
  AST_HOLD: assert property (flt_cnt > 2 && flt_cnt < FAIL_CYC - 1 && $past(ok)
    |-> safety_output_a && safety_output_b) else $error("outputs dropped early");
  AST_FAIL: assert property (flt_cnt > FAIL_CYC + 2 |-> !safety_output_a && !safety_output_b
    && led_red) else $error("failure state wrong");
  AST_WARN: assert property ($fell(safety_output_a) && $past(ok) |-> !diag_out)
    else $error("outputs dropped before warning");
  AST_CHAIN: assert property (!chn |=> !safety_output_a && !safety_output_b)
    else $error("outputs on without chain");
  AST_BLANK: assert property (req_cnt > BLANK_CYC + 1 && actuated && chn && !flt
    |=> safety_output_a && safety_output_b) else $error("blanking too long");
  cover property (flt_cnt == FAIL_CYC + 4);
  cover property (lim_cnt == 2 * DIAG_HALF + 6);
  cover property (req_cnt == BLANK_CYC + 2);
endmodule // ssdi_indicator_properties

bind ssdi_indicator ssdi_indicator_properties #(.ANALYSIS_CYC(ANALYSIS_CYC),
  .FAIL_CYC(FAIL_CYC), .DIAG_HALF(DIAG_HALF), .BLANK_CYC(BLANK_CYC)) u_props (.*);

// ### hdl/ssdi_flasher.v
/*
  red flash code generator: repeats a burst of count pulses, each pulse
  on_cyc + 1 cycles long, separated by gap_cyc + 1, bursts separated by pause_cyc + 1.
  assumes count is held stable while run is high.
*/
`timescale 1ns/10ps
`include "ssdi_defs.vh"

module ssdi_flasher #(
  parameter integer CW = 32
) (
  // clock and reset
  input  wire          clk,
  input  wire          rst,
  // control
  input  wire          run,
  input  wire [2:0]    count,
  input  wire [CW-1:0] on_cyc,
  input  wire [CW-1:0] gap_cyc,
  input  wire [CW-1:0] pause_cyc,
  // lamp drive
  output reg           lamp
);

  localparam [1:0] PH_ON    = 2'h0;  // pulse lit
  localparam [1:0] PH_GAP   = 2'h1;  // dark between pulses
  localparam [1:0] PH_PAUSE = 2'h2;  // dark between bursts

  reg [1:0]    phase_reg;  // current phase
  reg [CW-1:0] tmr_reg;    // cycles left in phase
  reg [2:0]    pulse_reg;  // pulses given in burst

  // phase sequencer
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      phase_reg <= PH_PAUSE;
      tmr_reg   <= {CW{1'b0}};
      pulse_reg <= 3'h0;
      lamp      <= 1'b0;
    end
    else if (!run)
    begin
      // idle: restart with a fresh burst
      phase_reg <= PH_PAUSE;
      tmr_reg   <= {CW{1'b0}};
      pulse_reg <= 3'h0;
      lamp      <= 1'b0;
    end
    else if (tmr_reg != {CW{1'b0}})
      tmr_reg <= tmr_reg - 1'b1;
    else
    begin
      case (phase_reg)
        PH_ON:
        begin
          // pulse done, count it
          lamp      <= 1'b0;
          pulse_reg <= pulse_reg + 3'h1;
          if (pulse_reg + 3'h1 >= count)
          begin
            phase_reg <= PH_PAUSE;
            tmr_reg   <= pause_cyc;
          end
          else
          begin
            phase_reg <= PH_GAP;
            tmr_reg   <= gap_cyc;
          end
        end
        PH_GAP, PH_PAUSE:
        begin
          // start next pulse
          if (phase_reg == PH_PAUSE)
            pulse_reg <= 3'h0;
          phase_reg <= PH_ON;
          tmr_reg   <= on_cyc;
          lamp      <= 1'b1;
        end
        default:
        begin
          phase_reg <= PH_PAUSE;
          lamp      <= 1'b0;
        end
      endcase
    end
  end

endmodule // ssdi_flasher

// ### hdl/ssdi_indicator.v
/*
  status and fault indication of a coded non-contact safety sensor:
  three-colour lamp, diagnostic output and redundant safety outputs.
  assumes all inputs synchronous to clk; fault inputs are levels from
  the sensing logic; safety inputs come from the previous chained sensor
  or are tied high by the outside wiring.
*/
// Overview of operation
// - ready and idle: green, outputs low
// - actuator in range: yellow, safety outputs on
// - limit range: yellow flashes, outputs stay on
// - coding, output, internal faults light red
// - new fault: steady red, then flash code
// - flash count gives fault class one to five
// - outputs stay on until fault lasts one minute
// - after one minute failure: steady red, outputs off
// - diagnostic high while actuated
// - diagnostic pulses 2 Hz near range limit
// - diagnostic drops ten seconds after fault
// - diagnostic warns before safety outputs drop
// - self-test blanking at most 2 ms
`timescale 1ns/10ps
`include "ssdi_defs.vh"

module ssdi_indicator #(
  parameter integer  CW           = 32,
  parameter integer  ANALYSIS_CYC = `SSDI_ANALYSIS_CYC,
  parameter [CW-1:0] FAIL_CYC     = `SSDI_FAIL_CYC,  // a minute exceeds the signed range
  parameter integer  DIAG_HALF    = `SSDI_DIAG_HALF_CYC,
  parameter integer  BLANK_CYC    = `SSDI_BLANK_CYC,
  parameter integer  YEL_HALF     = `SSDI_YEL_HALF_CYC,
  parameter integer  PULSE_CYC    = `SSDI_PULSE_CYC,
  parameter integer  GAP_CYC      = `SSDI_GAP_CYC,
  parameter integer  PAUSE_CYC    = `SSDI_PAUSE_CYC,
  parameter integer  CHAINED      = 1
) (
  // clock and reset
  input  wire clk,
  input  wire rst,
  // sensing conditions
  input  wire actuated,
  input  wire limit_range,
  // fault causes
  input  wire fault_out_a,
  input  wire fault_out_b,
  input  wire fault_cross,
  input  wire fault_temp,
  input  wire fault_coding,
  // chained safety inputs
  input  wire safety_input_a,
  input  wire safety_input_b,
  // self-test blanking request
  input  wire selftest_req,
  // lamp
  output reg  led_green,
  output reg  led_yellow,
  output wire led_red,
  // outputs
  output reg  diag_out,
  output reg  safety_output_a,
  output reg  safety_output_b
);

  reg [1:0]    state_reg;    // fault controller state
  reg [CW-1:0] ftmr_reg;     // time since fault appeared
  reg [2:0]    code_reg;     // latched fault class
  reg [CW-1:0] ytmr_reg;     // yellow flash divider
  reg          yel_ph_reg;   // yellow flash phase
  reg [CW-1:0] dtmr_reg;     // diagnostic 2 Hz divider
  reg          dph_reg;      // diagnostic pulse phase
  reg [CW-1:0] btmr_reg;     // blanking length counter
  reg          red_steady;   // steady red
  wire         flash_lamp;   // red flash pattern
  reg [2:0]    code_next;    // encoded fault class
  wire         any_fault;    // some fault present
  wire         inputs_ok;    // chain inputs satisfied
  reg          enable_next;  // safety enable before blanking

  // priority encoder: cross-wire outranks single-output faults
  always @*
  begin
    if (fault_cross)
      code_next = `SSDI_CODE_CROSS;
    else if (fault_out_a)
      code_next = `SSDI_CODE_OUT_A;
    else if (fault_out_b)
      code_next = `SSDI_CODE_OUT_B;
    else if (fault_temp)
      code_next = `SSDI_CODE_TEMP;
    else if (fault_coding)
      code_next = `SSDI_CODE_ACT;
    else
      code_next = `SSDI_CODE_NONE;
  end

  assign any_fault = (code_next != `SSDI_CODE_NONE);
  // chained inputs must both be high, single variants ignore them
  assign inputs_ok = (CHAINED == 0) || (safety_input_a && safety_input_b);

  // fault controller: analysis, warning, failure
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= `SSDI_ST_OK;
      ftmr_reg  <= {CW{1'b0}};
      code_reg  <= `SSDI_CODE_NONE;
    end
    else if (!any_fault)
    begin
      // fault gone: back to normal
      state_reg <= `SSDI_ST_OK;
      ftmr_reg  <= {CW{1'b0}};
      code_reg  <= `SSDI_CODE_NONE;
    end
    else
    begin
      case (state_reg)
        `SSDI_ST_OK:
        begin
          // new fault starts the analysis
          state_reg <= `SSDI_ST_ANALYSE;
          ftmr_reg  <= {CW{1'b0}};
          code_reg  <= code_next;
        end
        `SSDI_ST_ANALYSE:
        begin
          ftmr_reg <= ftmr_reg + 1'b1;
          if (ftmr_reg + 1'b1 >= ANALYSIS_CYC[CW-1:0])
            state_reg <= `SSDI_ST_WARN;
        end
        `SSDI_ST_WARN:
        begin
          ftmr_reg <= ftmr_reg + 1'b1;
          if (ftmr_reg + 1'b1 >= FAIL_CYC[CW-1:0])
            state_reg <= `SSDI_ST_FAIL;
        end
        `SSDI_ST_FAIL:
          state_reg <= `SSDI_ST_FAIL;
        default:
          state_reg <= `SSDI_ST_OK;
      endcase
    end
  end

  // yellow flash and diagnostic 2 Hz dividers
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ytmr_reg   <= {CW{1'b0}};
      yel_ph_reg <= 1'b1;
      dtmr_reg   <= {CW{1'b0}};
      dph_reg    <= 1'b1;
    end
    else if (!limit_range)
    begin
      // restart both patterns lit
      ytmr_reg   <= {CW{1'b0}};
      yel_ph_reg <= 1'b1;
      dtmr_reg   <= {CW{1'b0}};
      dph_reg    <= 1'b1;
    end
    else
    begin
      if (ytmr_reg + 1'b1 >= YEL_HALF[CW-1:0])
      begin
        ytmr_reg   <= {CW{1'b0}};
        yel_ph_reg <= ~yel_ph_reg;
      end
      else
        ytmr_reg <= ytmr_reg + 1'b1;
      if (dtmr_reg + 1'b1 >= DIAG_HALF[CW-1:0])
      begin
        dtmr_reg <= {CW{1'b0}};
        dph_reg  <= ~dph_reg;
      end
      else
        dtmr_reg <= dtmr_reg + 1'b1;
    end
  end

  // red flash code, only in the warning state
  ssdi_flasher #(
    .CW (CW)
  ) u_flasher (
    .clk       (clk),
    .rst       (rst),
    .run       (state_reg == `SSDI_ST_WARN),
    .count     (code_reg),
    .on_cyc    (PULSE_CYC[CW-1:0]),
    .gap_cyc   (GAP_CYC[CW-1:0]),
    .pause_cyc (PAUSE_CYC[CW-1:0]),
    .lamp      (flash_lamp)
  );

  // safety enable: needs actuation and chain inputs, off in failure, never delayed there
  always @*
  begin
    enable_next = actuated && inputs_ok && (state_reg != `SSDI_ST_FAIL);
  end

  // lamp, diagnostic and safety outputs
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      led_green       <= 1'b0;
      led_yellow      <= 1'b0;
      red_steady      <= 1'b0;
      diag_out        <= 1'b0;
      safety_output_a <= 1'b0;
      safety_output_b <= 1'b0;
      btmr_reg        <= {CW{1'b0}};
    end
    else
    begin
      // red steady during analysis and failure
      red_steady <= any_fault && ((state_reg == `SSDI_ST_OK) ||
                    (state_reg == `SSDI_ST_ANALYSE) ||
                    (state_reg == `SSDI_ST_FAIL));
      led_green  <= !any_fault && !actuated;
      led_yellow <= !any_fault && actuated &&
                    (!limit_range || yel_ph_reg);
      // diagnostic: high when actuated, pulsed at limit, low after analysis
      if (state_reg == `SSDI_ST_WARN || state_reg == `SSDI_ST_FAIL)
        diag_out <= 1'b0;
      else
        diag_out <= actuated && (!limit_range || dph_reg);
      // self-test blanking capped in length
      if (enable_next && selftest_req && btmr_reg < BLANK_CYC[CW-1:0])
      begin
        btmr_reg        <= btmr_reg + 1'b1;
        safety_output_a <= 1'b0;
        safety_output_b <= 1'b0;
      end
      else
      begin
        if (!selftest_req)
          btmr_reg <= {CW{1'b0}};
        safety_output_a <= enable_next;
        safety_output_b <= enable_next;
      end
    end
  end

  assign led_red = red_steady | flash_lamp;

endmodule // ssdi_indicator

// ### include/ssdi_defs.vh
/*
  shared constants of the safety sensor diagnostic indicator: timing
  figures in their own units, cycle counts derived from the clock rate,
  fault class codes and controller state codes.
  assumes a single 50 MHz clock.
*/
`ifndef SSDI_DEFS_VH
`define SSDI_DEFS_VH

// clock rate
`define SSDI_CLK_HZ          32'h02FAF080
// fault analysis time before diagnostic drop and flash code, seconds
`define SSDI_ANALYSIS_S      10
// pending fault time before the failure state, seconds
`define SSDI_FAIL_S          60
// diagnostic pulse rate near the range limit, hertz
`define SSDI_DIAG_HZ         2
// longest self-test blanking, milliseconds
`define SSDI_BLANK_MS        2
// derived counts
`define SSDI_ANALYSIS_CYC    (`SSDI_ANALYSIS_S * `SSDI_CLK_HZ)
`define SSDI_FAIL_CYC        (`SSDI_FAIL_S * `SSDI_CLK_HZ)
`define SSDI_DIAG_HALF_CYC   (`SSDI_CLK_HZ / (2 * `SSDI_DIAG_HZ))
`define SSDI_BLANK_CYC       ((`SSDI_BLANK_MS * `SSDI_CLK_HZ) / 1000)
// lamp flash timing, freely chosen: yellow at the diagnostic rate
`define SSDI_YEL_HALF_CYC    `SSDI_DIAG_HALF_CYC
`define SSDI_PULSE_CYC       (`SSDI_CLK_HZ / 5)
`define SSDI_GAP_CYC         (`SSDI_CLK_HZ / 5)
`define SSDI_PAUSE_CYC       `SSDI_CLK_HZ

// fault class codes, equal to the red flash count
`define SSDI_CODE_NONE       3'h0
`define SSDI_CODE_OUT_A      3'h1
`define SSDI_CODE_OUT_B      3'h2
`define SSDI_CODE_CROSS      3'h3
`define SSDI_CODE_TEMP       3'h4
`define SSDI_CODE_ACT        3'h5

// controller states
`define SSDI_ST_OK           2'h0
`define SSDI_ST_ANALYSE      2'h1
`define SSDI_ST_WARN         2'h2
`define SSDI_ST_FAIL         2'h3

`endif
